// ---- src/fetch_ctl_pkg.sv ----
// Shared constants and carriers for the instruction issue and fetch control block.
// Assumes one core clock; registers reached over a 32-bit Avalon-MM slave.
`default_nettype none
package fetch_ctl_pkg;
   localparam int PC_W        = 43;
   localparam int PA_W        = 34;
   localparam int HIST_IDX_W  = 11;
   localparam int HIST_DEPTH  = 2048;
   localparam int LINE_SLOTS  = 8;
   localparam int SP_IDX_W    = 3;               // Eight small-page entries
   localparam int LP_IDX_W    = 2;               // Four large-page entries
   localparam int SP_N        = 8;
   localparam int LP_N        = 4;
   localparam int RS_N        = 4;
   localparam int RS_IDX_W    = 2;
   localparam int PAGE_LSB    = 13;              // 8K byte pages
   localparam int LARGE_LSB   = 22;              // 512 contiguous 8K pages
   localparam int TAG_W       = PC_W - PAGE_LSB;
   localparam int PFN_W       = PA_W - PAGE_LSB;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_FLUSH   = 8'h04;
   localparam logic [7:0] OFS_SOFT_IRQ_REQUEST_REG    = 8'h08;
   localparam logic [7:0] OFS_TRAPRQ  = 8'h0C;
   localparam logic [7:0] OFS_SOFT_IRQ_ENABLE_REG    = 8'h10;
   localparam logic [7:0] OFS_HW_IRQ_ENABLE_REG    = 8'h14;
   localparam logic [7:0] OFS_HW_IRQ_REQUEST_REG    = 8'h18;
   localparam logic [7:0] OFS_TRAPEN  = 8'h1C;
   localparam logic [7:0] OFS_RST_LO  = 8'h20;
   localparam logic [7:0] OFS_RST_HI  = 8'h24;
   localparam logic [7:0] OFS_ITAG    = 8'h28;
   localparam logic [7:0] OFS_IPTE    = 8'h2C;
   // Field positions
   localparam int CTRL_HIST_BIT  = 0;
   localparam int CTRL_PRED_BIT  = 1;
   localparam int CTRL_MAP_BIT   = 2;
   localparam int CTRL_MODE_LSB  = 3;
   localparam int PTE_ASM_BIT    = 24;
   localparam int PTE_PROT_LSB   = 25;
   localparam int PTE_LARGE_BIT  = 31;
   localparam int SOFT_IRQ_ENABLE_REG_TRAP_GATE = 2;
   // Reset values and codes
   localparam logic       HIST_EN_RST = 1'b1;
   localparam logic       PRED_EN_RST = 1'b1;
   localparam logic [1:0] MODE_KERNEL = 2'h0;
   localparam logic [1:0] SP_REGION   = 2'h2;

   typedef enum logic [1:0] {RS_NONE, RS_PUSH, RS_POP, RS_SWAP} rs_hint_e;
   typedef enum logic {IRQ_IDLE, IRQ_DRAIN} irq_state_e;

   typedef struct packed {
      logic             valid;
      logic [TAG_W-1:0] tag;
      logic [PFN_W-1:0] pfn;
      logic             asm_bit;
      logic [3:0]       prot;                     // Access enable per mode
   } itb_entry_s;

   typedef struct packed {
      logic [1:0] valid;
      logic [1:0] res_ok;
      logic       aligned;
   } issue_req_s;

   typedef struct packed {
      logic            hit;
      logic            miss;
      logic            viol;
      logic            asm_bit;
      logic [PA_W-1:0] phys;
   } xlate_s;

   typedef struct packed {
      logic                           hist_en;
      logic                           pred_en;
      logic                           map_en;
      logic [1:0]                     mode;
      logic [15:1]                    soft_irq_request_reg;
      logic [15:1]                    soft_irq_enable_reg;
      logic [6:1]                     hw_irq_enable_reg;
      logic [3:0]                     trap_request_reg;
      logic [3:0]                     aster;
      logic [PC_W-1:0]                restart;
      logic [TAG_W-1:0]               tag_stage;
      itb_entry_s [SP_N-1:0]          sp;
      itb_entry_s [LP_N-1:0]          lp;
      logic [SP_IDX_W-1:0]            sp_last;
      logic [LP_IDX_W-1:0]            lp_last;
      logic [HIST_DEPTH-1:0]          hist;
      logic [HIST_DEPTH-1:0]          seen;
      logic [RS_N-1:0][PC_W-1:0]      rs;
      logic [RS_IDX_W-1:0]            rs_ptr;
      logic                           second_pend;
      irq_state_e                     irq;
      logic                           plm;
      logic                           take;
      logic                           ack;
      logic [31:0]                    rdata;
      xlate_s                         xl;
   } state_s;
endpackage : fetch_ctl_pkg
`default_nettype wire

// ---- src/instruction_issue_fetch_control.sv ----
// Instruction issue, branch prediction, fetch translation and interrupt control.
// Assumes inputs synchronous to core_clk_in and a well-behaved Avalon-MM master.
`default_nettype none
module instruction_issue_fetch_control (
   input  wire logic                                core_clk_in,
   input  wire logic                                rst_in,
   // Avalon-MM register slave
   input  wire logic [7:0]                          avs_address_in,
   input  wire logic                                avs_read_in,
   input  wire logic                                avs_write_in,
   input  wire logic [31:0]                         avs_writedata_in,
   output logic [31:0]                              avs_readdata_out,
   output logic                                     avs_waitrequest_out,
   // Issue
   input  wire fetch_ctl_pkg::issue_req_s           issue_req_in,
   output logic [1:0]                               issue_out,
   // Branch prediction and return stack
   input  wire logic                                br_valid_in,
   input  wire logic                                br_cond_in,
   input  wire logic                                br_disp_sign_in,
   input  wire logic [fetch_ctl_pkg::HIST_IDX_W-1:0] br_index_in,
   output logic                                     pred_taken_out,
   input  wire logic                                br_resolve_in,
   input  wire logic [fetch_ctl_pkg::HIST_IDX_W-1:0] br_resolve_index_in,
   input  wire logic                                br_resolve_taken_in,
   input  wire logic                                icache_fill_in,
   input  wire logic [fetch_ctl_pkg::HIST_IDX_W-4:0] icache_fill_line_in,
   input  wire fetch_ctl_pkg::rs_hint_e             rs_hint_in,
   input  wire logic [fetch_ctl_pkg::PC_W-1:0]      rs_link_in,
   output logic [fetch_ctl_pkg::PC_W-1:0]           rs_top_out,
   // Fetch translation
   input  wire logic                                fetch_valid_in,
   input  wire logic [fetch_ctl_pkg::PC_W-1:0]      virtual_fetch_pc_in,
   output fetch_ctl_pkg::xlate_s                    xlate_out,
   // Interrupts
   input  wire logic [6:1]                          hw_irq_in,
   input  wire logic                                pipe_empty_in,
   input  wire logic                                dfill_idle_in,
   input  wire logic [fetch_ctl_pkg::PC_W-1:0]      restart_pc_in,
   input  wire logic                                privileged_return_instr_in,
   output logic                                     irq_vector_out,
   output logic                                     privileged_library_mode_out
);
   import fetch_ctl_pkg::*;

   state_s st_reg;
   state_s st_next;

   logic                 drain;
   logic                 hw_pend;
   logic                 sw_pend;
   logic                 trap_pend;
   logic                 any_pend;
   logic                 use_hist;
   logic [PC_W-1:0]      virtual_fetch_pc;
   logic [SP_IDX_W-1:0]  sp_vict;
   logic [LP_IDX_W-1:0]  lp_vict;
   itb_entry_s           new_ent;
   xlate_s               x;

   assign virtual_fetch_pc = virtual_fetch_pc_in;

   // Bus handshake: one wait cycle, then readdata from flops
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st_reg.ack;
   assign avs_readdata_out    = st_reg.rdata;

   // Interrupt qualification, evaluated on live request state
   always_comb begin
      hw_pend   = |(hw_irq_in & st_reg.hw_irq_enable_reg);
      sw_pend   = |(st_reg.soft_irq_request_reg & st_reg.soft_irq_enable_reg);
      trap_pend = 1'b0;
      for (int i = 0; i < 4; i++) begin
         // Mode numbers rise toward less privilege; a more privileged mode blocks
         if (st_reg.trap_request_reg[i] && st_reg.aster[i] && st_reg.soft_irq_enable_reg[SOFT_IRQ_ENABLE_REG_TRAP_GATE]
             && (st_reg.mode >= 2'(i))) begin
            trap_pend = 1'b1;
         end
      end
      any_pend = hw_pend | sw_pend | trap_pend;
   end

   assign drain = (st_reg.irq == IRQ_DRAIN);

   // Branch prediction is a same-cycle answer to the prefetcher
   always_comb begin
      use_hist       = st_reg.hist_en && st_reg.seen[br_index_in];
      pred_taken_out = st_reg.pred_en && br_valid_in &&
                       (!br_cond_in ||
                        (use_hist ? st_reg.hist[br_index_in] : br_disp_sign_in));
   end

   assign rs_top_out                  = st_reg.rs[st_reg.rs_ptr];
   assign xlate_out                   = st_reg.xl;
   assign irq_vector_out              = st_reg.take;
   assign privileged_library_mode_out = st_reg.plm;
   assign sp_vict = st_reg.sp_last + SP_IDX_W'(1);
   assign lp_vict = st_reg.lp_last + LP_IDX_W'(1);

   // Entry built from the staged tag and the written table entry
   always_comb begin
      new_ent         = '0;
      new_ent.valid   = 1'b1;
      new_ent.tag     = st_reg.tag_stage;
      new_ent.pfn     = avs_writedata_in[PFN_W-1:0];
      new_ent.asm_bit = avs_writedata_in[PTE_ASM_BIT];
      new_ent.prot    = avs_writedata_in[PTE_PROT_LSB +: 4];
   end

   // Next-state logic for the whole block
   always_comb begin
      st_next      = st_reg;
      st_next.ack  = 1'b0;
      st_next.take = 1'b0;
      issue_out    = 2'b00;

      // Fetch translation; a later fill in this cycle overrides the last-used index
      x = '0;
      if (fetch_valid_in) begin
         if (st_reg.plm) begin
            x.hit  = 1'b1;
            x.phys = virtual_fetch_pc[PA_W-1:0];
         end else if (st_reg.map_en && virtual_fetch_pc[PC_W-1 -: 2] == SP_REGION) begin
            x.hit     = 1'b1;
            x.asm_bit = 1'b1;
            x.phys    = virtual_fetch_pc[PA_W-1:0];
            x.viol    = (st_reg.mode != MODE_KERNEL);
         end else begin
            for (int i = 0; i < SP_N; i++) begin
               if (st_reg.sp[i].valid && st_reg.sp[i].tag == virtual_fetch_pc[PC_W-1:PAGE_LSB]) begin
                  x.hit           = 1'b1;
                  x.asm_bit       = st_reg.sp[i].asm_bit;
                  x.phys          = {st_reg.sp[i].pfn, virtual_fetch_pc[PAGE_LSB-1:0]};
                  x.viol          = !st_reg.sp[i].prot[st_reg.mode];
                  st_next.sp_last = SP_IDX_W'(i);
               end
            end
            for (int i = 0; i < LP_N; i++) begin
               if (st_reg.lp[i].valid &&
                   st_reg.lp[i].tag[TAG_W-1:LARGE_LSB-PAGE_LSB] == virtual_fetch_pc[PC_W-1:LARGE_LSB]) begin
                  x.hit           = 1'b1;
                  x.asm_bit       = st_reg.lp[i].asm_bit;
                  x.phys          = {st_reg.lp[i].pfn[PFN_W-1:LARGE_LSB-PAGE_LSB],
                                     virtual_fetch_pc[LARGE_LSB-1:0]};
                  x.viol          = !st_reg.lp[i].prot[st_reg.mode];
                  st_next.lp_last = LP_IDX_W'(i);
               end
            end
         end
         x.miss = !x.hit;
      end
      st_next.xl = x;

      // Register reads captured and requests acknowledged in the first cycle of a request
      if ((avs_read_in || avs_write_in) && !st_reg.ack) begin
         st_next.ack   = 1'b1;
         st_next.rdata = '0;
         if (avs_read_in) begin
            case (avs_address_in)
               OFS_CTRL:   st_next.rdata[4:0] = {st_reg.mode, st_reg.map_en,
                                                 st_reg.pred_en, st_reg.hist_en};
               OFS_SOFT_IRQ_REQUEST_REG:   st_next.rdata[15:1] = st_reg.soft_irq_request_reg;
               OFS_TRAPRQ: st_next.rdata[3:0]  = st_reg.trap_request_reg;
               OFS_SOFT_IRQ_ENABLE_REG:   st_next.rdata[15:1] = st_reg.soft_irq_enable_reg;
               OFS_HW_IRQ_ENABLE_REG:   st_next.rdata[6:1]  = st_reg.hw_irq_enable_reg;
               OFS_HW_IRQ_REQUEST_REG:   st_next.rdata[6:1]  = hw_irq_in;
               OFS_TRAPEN: st_next.rdata[3:0]  = st_reg.aster;
               OFS_RST_LO: st_next.rdata       = st_reg.restart[31:0];
               OFS_RST_HI: st_next.rdata[PC_W-33:0] = st_reg.restart[PC_W-1:32];
               OFS_ITAG:   st_next.rdata[TAG_W-1:0] = st_reg.tag_stage;
               default:    st_next.rdata = '0;                          // Unmapped reads zero
            endcase
         end
      end

      // Writes land at the completing edge, when waitrequest is low
      if (avs_write_in && st_reg.ack) begin
            case (avs_address_in)
               OFS_CTRL: begin
                  st_next.hist_en = avs_writedata_in[CTRL_HIST_BIT];
                  st_next.pred_en = avs_writedata_in[CTRL_PRED_BIT];
                  st_next.map_en  = avs_writedata_in[CTRL_MAP_BIT];
                  st_next.mode    = avs_writedata_in[CTRL_MODE_LSB +: 2];
               end
               OFS_FLUSH: begin
                  for (int i = 0; i < SP_N; i++) begin
                     if (!st_reg.sp[i].asm_bit) st_next.sp[i].valid = 1'b0;
                  end
                  for (int i = 0; i < LP_N; i++) begin
                     if (!st_reg.lp[i].asm_bit) st_next.lp[i].valid = 1'b0;
                  end
               end
               OFS_SOFT_IRQ_REQUEST_REG:   st_next.soft_irq_request_reg  = avs_writedata_in[15:1];
               OFS_TRAPRQ: st_next.trap_request_reg = avs_writedata_in[3:0];
               OFS_SOFT_IRQ_ENABLE_REG:   st_next.soft_irq_enable_reg  = avs_writedata_in[15:1];
               OFS_HW_IRQ_ENABLE_REG:   st_next.hw_irq_enable_reg  = avs_writedata_in[6:1];
               OFS_TRAPEN: st_next.aster = avs_writedata_in[3:0];
               OFS_ITAG:   st_next.tag_stage = avs_writedata_in[TAG_W-1:0];
               OFS_IPTE: begin
                  // Fill goes to the entry that was not last used
                  if (avs_writedata_in[PTE_LARGE_BIT]) begin
                     st_next.lp[lp_vict] = new_ent;
                     st_next.lp_last     = lp_vict;
                  end else begin
                     st_next.sp[sp_vict] = new_ent;
                     st_next.sp_last     = sp_vict;
                  end
               end
               default: ;                                               // Writes ignored
            endcase
      end

      // History bits: a cache refill forgets the line, a resolve records after it
      if (icache_fill_in) begin
         for (int j = 0; j < LINE_SLOTS; j++) begin
            st_next.seen[{icache_fill_line_in, 3'(j)}] = 1'b0;
         end
      end
      if (br_resolve_in) begin
         st_next.hist[br_resolve_index_in] = br_resolve_taken_in;
         st_next.seen[br_resolve_index_in] = 1'b1;
      end

      // Return stack; frozen while prediction hardware is disabled
      if (st_reg.pred_en) begin
         unique case (rs_hint_in)
            RS_PUSH: begin
               st_next.rs_ptr             = st_reg.rs_ptr + RS_IDX_W'(1);
               st_next.rs[st_next.rs_ptr] = rs_link_in;
            end
            RS_POP:  st_next.rs_ptr = st_reg.rs_ptr - RS_IDX_W'(1);
            RS_SWAP: st_next.rs[st_reg.rs_ptr] = rs_link_in;
            RS_NONE: ;
         endcase
      end

      // In-order issue; nothing issues while draining for an interrupt
      if (!drain) begin
         if (st_reg.second_pend) begin
            // Remaining second goes alone, never re-paired
            if (issue_req_in.res_ok[1]) begin
               issue_out           = 2'b10;
               st_next.second_pend = 1'b0;
            end
         end else if (issue_req_in.aligned && issue_req_in.valid == 2'b11) begin
            if (issue_req_in.res_ok == 2'b11) begin
               issue_out = 2'b11;
            end else if (issue_req_in.res_ok[0]) begin
               issue_out           = 2'b01;
               st_next.second_pend = 1'b1;
            end
         end else if (issue_req_in.valid[0] && issue_req_in.res_ok[0]) begin
            issue_out = 2'b01;
         end
      end

      // Interrupt delivery; library mode holds requests off until it exits
      unique case (st_reg.irq)
         IRQ_IDLE: begin
            if (privileged_return_instr_in && st_reg.plm) begin
               st_next.plm = 1'b0;
            end else if (any_pend && !st_reg.plm) begin
               st_next.irq = IRQ_DRAIN;
            end
         end
         IRQ_DRAIN: begin
            if (!any_pend) begin
               st_next.irq = IRQ_IDLE;
            end else if (pipe_empty_in && dfill_idle_in) begin
               st_next.restart = restart_pc_in;
               st_next.plm     = 1'b1;
               st_next.take    = 1'b1;
               st_next.irq     = IRQ_IDLE;
            end
         end
      endcase
   end

   // State register; reset loads constants only
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg         <= '0;
         st_reg.hist_en <= HIST_EN_RST;
         st_reg.pred_en <= PRED_EN_RST;
         st_reg.irq     <= IRQ_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : instruction_issue_fetch_control
`default_nettype wire

// ---- bench/fetch_ctl_props.sv ----
// Assertions on issue order, library fetch and interrupt delivery.
// Sees only the top module's ports; bound to it at the foot of the file.
`default_nettype none
module fetch_ctl_props (
   input wire logic                      core_clk_in,
   input wire logic                      rst_in,
   input wire fetch_ctl_pkg::issue_req_s issue_req_in,
   input wire logic [1:0]                issue_out,
   input wire logic                      fetch_valid_in,
   input wire logic [42:0]               virtual_fetch_pc_in,
   input wire fetch_ctl_pkg::xlate_s     xlate_out,
   input wire logic [6:1]                hw_irq_in,
   input wire logic                      pipe_empty_in,
   input wire logic                      dfill_idle_in,
   input wire logic                      irq_vector_out,
   input wire logic                      privileged_library_mode_out
);
   import fetch_ctl_pkg::*;
   logic pend_reg; // Second slot of an aligned pair still owed
   logic calm_reg; // No pin request last cycle, so no pin-driven drain can block issue
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   // Mirror of the owed slot; a drain blocks issue, hence the calm filter
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pend_reg <= 1'b0;
         calm_reg <= 1'b1;
      end else begin
         pend_reg <= !issue_out[1] && (pend_reg || (issue_out[0] && issue_req_in.aligned
            && issue_req_in.valid[1]));
         calm_reg <= (hw_irq_in == 6'h00);
      end
   end
   sequence pair_ready_s;
      issue_req_in.valid == 2'b11 && issue_req_in.res_ok == 2'b11 && issue_req_in.aligned;
   endsequence
   sequence delivered_s;
      irq_vector_out && privileged_library_mode_out;
   endsequence
   dual_issue_a:
      assert property ((!pend_reg && calm_reg && hw_irq_in == 6'h00) ##0 pair_ready_s
         |-> issue_out == 2'b11) else $error("ready pair not dual issued");
   in_order_a:
      assert property (!pend_reg && !issue_req_in.res_ok[0] |-> issue_out == 2'b00)
         else $error("issue without first slot");
   no_refill_a:
      assert property (pend_reg |-> !issue_out[0]) else $error("new pair while slot owed");
   quad_pair_a:
      assert property (!pend_reg && !issue_req_in.aligned |-> !issue_out[1])
         else $error("unaligned pair dual issued");
   lib_xlate_a:
      assert property (fetch_valid_in && privileged_library_mode_out ##1
         privileged_library_mode_out |-> xlate_out.hit
         && xlate_out.phys == $past(virtual_fetch_pc_in[33:0])) else $error("library fetch");
   drained_first_a:
      assert property (delivered_s |-> $past(pipe_empty_in && dfill_idle_in)
         && !$past(privileged_library_mode_out)) else $error("delivery before drain");
   lib_enter_a:
      assert property ($rose(privileged_library_mode_out) |-> irq_vector_out)
         else $error("library mode without delivery");
   lib_hold_a:
      assert property (privileged_library_mode_out && $past(privileged_library_mode_out)
         |-> !irq_vector_out) else $error("delivery inside library mode");
endmodule : fetch_ctl_props
bind instruction_issue_fetch_control fetch_ctl_props u_props (
   .core_clk_in, .rst_in, .issue_req_in, .issue_out, .fetch_valid_in, .virtual_fetch_pc_in,
   .xlate_out, .hw_irq_in, .pipe_empty_in, .dfill_idle_in, .irq_vector_out,
   .privileged_library_mode_out);
`default_nettype wire

// ---- bench/exec_side_model.sv ----
// Execution units' drain status and the six external request pins.
// Driven by the bench just after clock edges; one clock.
`default_nettype none
module exec_side_model (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic [7:0] busy_in,
   input  wire logic [6:1] pin_set_in,
   input  wire logic [6:1] pin_clr_in,
   output logic            pipe_empty_out,
   output logic            dfill_idle_out,
   output logic [6:1]      hw_irq_out
);
   logic [7:0] busy_reg;
   // A request stays up until the bench withdraws it, as a level source must
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_reg   <= 8'h00;
         hw_irq_out <= 6'h00;
      end else begin
         busy_reg   <= (busy_in != 8'h00) ? busy_in : busy_reg - {7'h00, busy_reg != 8'h00};
         hw_irq_out <= (hw_irq_out | pin_set_in) & ~pin_clr_in;
      end
   end
   // Fills end two cycles after the pipe empties, so delivery must wait for both
   assign pipe_empty_out = (busy_reg <= 8'h02);
   assign dfill_idle_out = (busy_reg == 8'h00);
endmodule : exec_side_model
`default_nettype wire

// ---- bench/tb.sv ----
// Bench for the issue, prediction, fetch translation and interrupt block.
// Registers reached as an Avalon-MM master; the side model drives pins and drain.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import fetch_ctl_pkg::*;
   localparam logic [42:0] RPC = 43'h5A512345678; // Restart PC offered at delivery
   localparam logic [6:0]  ISS [6] = '{7'h7F, 7'h74, 7'h6D, 7'h7E, 7'h79, 7'h00};
   logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wreq, vec, plm, pt, pe, di;
   logic        bv = 1'b0, bc = 1'b0, bs = 1'b0, bres = 1'b0, fill = 1'b0, fv = 1'b0, pret = 1'b0;
   logic [7:0]  adr = 8'h00, busy = 8'h00;
   logic [31:0] wdat = 32'h0, rdq, rdat;
   logic [42:0] pc = 43'h0, link = 43'h0, top;
   logic [6:1]  hw, pset = 6'h00, pclr = 6'h00;
   logic [1:0]  iss;
   issue_req_s  ireq = '0;
   rs_hint_e    hint = RS_NONE;
   xlate_s      xo, xv;
   int          error_cnt = 0, compares = 0, cyc = 0;
   instruction_issue_fetch_control u_dut (.core_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdq),
      .avs_waitrequest_out(wreq), .issue_req_in(ireq), .issue_out(iss), .br_valid_in(bv),
      .br_cond_in(bc), .br_disp_sign_in(bs), .br_index_in(11'h005), .pred_taken_out(pt),
      .br_resolve_in(bres), .br_resolve_index_in(11'h005), .br_resolve_taken_in(1'b0),
      .icache_fill_in(fill), .icache_fill_line_in(8'h00), .rs_hint_in(hint), .rs_link_in(link),
      .rs_top_out(top), .fetch_valid_in(fv), .virtual_fetch_pc_in(pc), .xlate_out(xo),
      .hw_irq_in(hw), .pipe_empty_in(pe), .dfill_idle_in(di), .restart_pc_in(RPC),
      .privileged_return_instr_in(pret), .irq_vector_out(vec), .privileged_library_mode_out(plm));
   exec_side_model u_side (.clk_in(clk), .rst_in(rst), .busy_in(busy), .pin_set_in(pset),
      .pin_clr_in(pclr), .pipe_empty_out(pe), .dfill_idle_out(di), .hw_irq_out(hw));
   initial begin
      forever #10 clk = ~clk;
   end
   // The tests need under two thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Request held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      {rd, wr} <= {!w, w};
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0); // Only the bench timeout ends a hung wait
      rdat = rdq;
      {rd, wr} <= 2'b00;
   endtask : bus
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask : rdc
   task automatic step(input logic [6:0] t);
      @(posedge clk);
      ireq <= t[6:2];
      @(negedge clk);
      chk(iss, t[1:0]);
   endtask : step
   task automatic pr(input logic c, input logic s, input logic e);
      @(posedge clk);
      {bv, bc, bs} <= {1'b1, c, s};
      @(negedge clk);
      chk(pt, e);
   endtask : pr
   task automatic pulse(input logic r, input logic f, input logic p);
      @(posedge clk);
      {bres, fill, pret} <= {r, f, p};
      @(posedge clk);
      {bres, fill, pret} <= 3'h0;
   endtask : pulse
   task automatic rs(input rs_hint_e h, input logic [42:0] l, input logic [42:0] e);
      @(posedge clk);
      hint <= h;
      link <= l;
      @(posedge clk);
      hint <= RS_NONE;
      @(negedge clk);
      chk(top, e);
   endtask : rs
   task automatic xl(input logic [42:0] p);
      @(posedge clk);
      fv <= 1'b1;
      pc <= p;
      @(posedge clk);
      fv <= 1'b0;
      @(negedge clk);
      xv = xo;
   endtask : xl
   task automatic pin(input logic [6:1] s, input logic [6:1] c, input logic [7:0] b);
      @(posedge clk);
      {pset, pclr, busy} <= {s, c, b};
      @(posedge clk);
      {pset, pclr, busy} <= 20'h0;
   endtask : pin
   task automatic wait_vec(input logic e);
      logic got;
      got = 1'b0;
      repeat (30) begin
         @(negedge clk);
         got = got | vec;
      end
      chk(got, e);
   endtask : wait_vec
   task automatic wrap_up();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // Main sequence: registers, issue, prediction, stack, translation, interrupts
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(OFS_CTRL, 32'h3);
      bus(1'b1, 8'hF0, 32'hFFFFFFFF);
      rdc(8'hF0, 32'h0);
      for (int i = 0; i < 6; i++) step(ISS[i]);
      pr(1'b1, 1'b1, 1'b1);
      pr(1'b1, 1'b0, 1'b0);
      pr(1'b0, 1'b0, 1'b1);
      pulse(1'b1, 1'b0, 1'b0);
      pr(1'b1, 1'b1, 1'b0);
      bus(1'b1, OFS_CTRL, 32'h2);
      pr(1'b1, 1'b1, 1'b1);
      bus(1'b1, OFS_CTRL, 32'h0);
      pr(1'b0, 1'b0, 1'b0);
      bus(1'b1, OFS_CTRL, 32'h3);
      pr(1'b1, 1'b1, 1'b0);
      pulse(1'b0, 1'b1, 1'b0);
      pr(1'b1, 1'b1, 1'b1);
      rs(RS_PUSH, 43'h111, 43'h111);
      rs(RS_PUSH, 43'h222, 43'h222);
      rs(RS_POP, 43'h0, 43'h111);
      rs(RS_SWAP, 43'h333, 43'h333);
      bus(1'b1, OFS_CTRL, 32'h7);
      xl(43'h40123456789);
      chk(xv, {4'b1001, 34'h123456789});
      bus(1'b1, OFS_CTRL, 32'h1F);
      xl(43'h40123456789);
      chk(xv[37:34], 4'b1011);
      bus(1'b1, OFS_CTRL, 32'h7);
      bus(1'b1, OFS_ITAG, 32'h2);
      bus(1'b1, OFS_IPTE, 32'h1E000015);
      xl(43'h4000);
      chk(xv, {4'b1000, 34'h2A000});
      bus(1'b1, OFS_ITAG, 32'h3);
      bus(1'b1, OFS_IPTE, 32'h1F000016);
      xl(43'h6000);
      chk(xv, {4'b1001, 34'h2C000});
      xl(43'h4000);
      chk(xv[37], 1'b1);
      bus(1'b1, OFS_FLUSH, 32'h0);
      xl(43'h4000);
      chk(xv[37:36], 2'b01);
      xl(43'h6000);
      chk(xv[37:36], 2'b10);
      bus(1'b1, OFS_HW_IRQ_ENABLE_REG, 32'h40);
      pin(6'h04, 6'h00, 8'h00);
      rdc(OFS_HW_IRQ_REQUEST_REG, 32'h8);
      wait_vec(1'b0);
      pin(6'h20, 6'h00, 8'h06);
      wait_vec(1'b1);
      chk(plm, 1'b1);
      rdc(OFS_RST_LO, RPC[31:0]);
      rdc(OFS_RST_HI, {21'h0, RPC[42:32]});
      xl(43'h4000);
      chk(xv[37], 1'b1);
      wait_vec(1'b0);
      pin(6'h00, 6'h3F, 8'h00);
      rdc(OFS_HW_IRQ_REQUEST_REG, 32'h0);
      bus(1'b1, OFS_SOFT_IRQ_ENABLE_REG, 32'h2);
      bus(1'b1, OFS_SOFT_IRQ_REQUEST_REG, 32'h2);
      wait_vec(1'b0);
      pulse(1'b0, 1'b0, 1'b1);
      wait_vec(1'b1);
      bus(1'b1, OFS_SOFT_IRQ_REQUEST_REG, 32'h0);
      pulse(1'b0, 1'b0, 1'b1);
      bus(1'b1, OFS_TRAPEN, 32'h1);
      bus(1'b1, OFS_TRAPRQ, 32'h1);
      wait_vec(1'b0);
      bus(1'b1, OFS_SOFT_IRQ_ENABLE_REG, 32'h6);
      wait_vec(1'b1);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
